// file: dv/pfdc_port_ctrl_tb.sv
// Self-checking bench for the port pin function and drive control block
`timescale 1ns/1ns
`default_nettype none
`include "pfdc_defines.svh"
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module pfdc_port_ctrl_tb;
    logic       sys_clk   = 1'b0;
    logic       rst       = 1'b1;
    logic       addrWr    = 1'b0;
    logic       ctrlWr    = 1'b0;
    logic       ctrlRd    = 1'b0;
    logic [7:0] wrData    = 8'h00;
    logic [7:0] dirBits   = 8'h00;
    logic [7:0] portOut   = 8'h00;
    logic [7:0] periphOut = 8'h00;
    logic [7:0] periphOe  = 8'h00;
    wire  logic [7:0] rdData, portIndex, padOut, padOe, padHi, altBits, odBits;
    int         errors          = 0;
    int         samples_checked = 0;
    int         cycles          = 0;

    pfdc_port_ctrl u_pfdc_port_ctrl (.sys_clk(sys_clk), .rst(rst), .addrWr(addrWr), .ctrlWr(ctrlWr),
        .ctrlRd(ctrlRd), .wrData(wrData), .rdData(rdData), .portIndex(portIndex), .pin_direction_bit(dirBits),
        .portOut(portOut), .periphOut(periphOut), .periphOe(periphOe), .padOut(padOut), .padOe(padOe),
        .padHi(padHi), .alt_func_bits(altBits), .open_drain_bits(odBits));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish();
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Index write then one control access, back to back
    task automatic acc(input logic [7:0] idx, input logic [7:0] val, input logic doWr);
        @(posedge sys_clk);
        addrWr <= 1'b1;
        wrData <= idx;
        @(posedge sys_clk);
        addrWr <= 1'b0;
        ctrlWr <= doWr;
        ctrlRd <= ~doWr;
        wrData <= val;
        @(posedge sys_clk);
        ctrlWr <= 1'b0;
        ctrlRd <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask : acc

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    initial begin : main
        logic [7:0] alt, od, hd, src;
        int         seed;
        seed = 32'h711f2206;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        `CHK("openDrainReset", 8'h00, odBits)
        `CHK("padOeReset", 8'h00, padOe)
        for (int i = 0; i < 40; i++) begin
            alt = 8'($random(seed));
            od  = 8'($random(seed));
            hd  = 8'($random(seed));
            // First passes pin the corners: all peripheral plus open drain, then all port
            if (i == 0) begin alt = 8'hff; od = 8'hff; end
            if (i == 1) begin alt = 8'h00; od = 8'h00; hd = 8'hff; end
            @(posedge sys_clk);
            dirBits   <= 8'($random(seed));
            portOut   <= 8'($random(seed));
            periphOut <= 8'($random(seed));
            periphOe  <= 8'($random(seed));
            acc(`PFDC_IDX_ALTFN, alt, 1'b1);
            acc(8'h03, od, 1'b1);
            acc(8'h04, hd, 1'b1);
            acc(8'h05, 8'($random(seed)), 1'b1);
            acc(8'h05, 8'h00, 1'b0);
            `CHK("rdUnmapped", 8'h00, rdData)
            acc(8'h03, 8'h00, 1'b0);
            `CHK("rdOpenDrain", od, rdData)
            acc(8'h04, 8'h00, 1'b0);
            `CHK("rdHiDrive", hd, rdData)
            `CHK("portIndex", 8'h04, portIndex)
            acc(`PFDC_IDX_ALTFN, 8'h00, 1'b0);
            `CHK("rdAltFunc", alt, rdData)
            `CHK("altBits", alt, altBits)
            `CHK("odBits", od, odBits)
            src = (alt & periphOut) | (~alt & portOut);
            `CHK("padOut", src, padOut)
            `CHK("padOe", ((alt & periphOe) | (~alt & ~dirBits)) & ~(od & src), padOe)
            `CHK("padHi", hd, padHi)
        end
        // Reset in mid-run must drop open drain again; set it first so the check can fail
        acc(8'h03, 8'hff, 1'b1);
        `CHK("odBeforeReset", 8'hff, odBits)
        @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        #1;
        `CHK("openDrainReReset", 8'h00, odBits)
        `CHK("padOeReReset", 8'h00, padOe)
        @(posedge sys_clk);
        rst <= 1'b0;
        acc(8'h03, 8'h5a, 1'b1);
        `CHK("odAfterReset", 8'h5a, odBits)
        tally_and_finish();
    end
endmodule : pfdc_port_ctrl_tb
`default_nettype wire

// file: hdl/pfdc_defines.svh
// Constants for the port pin function and drive control block
`ifndef PFDC_DEFINES_SVH
`define PFDC_DEFINES_SVH
`define PFDC_IDX_ALTFN     8'h02
`define PFDC_IDX_OPENDRAIN 8'h03
`define PFDC_IDX_HIDRIVE   8'h04
`define PFDC_RST_ALTFN     8'h00
`define PFDC_RST_OPENDRAIN 8'h00
`define PFDC_RST_HIDRIVE   8'h00
`define PFDC_RST_INDEX     8'h00
`define PFDC_RD_ZERO       8'h00
`define PFDC_RST_PINS      8'h00
`endif

// file: hdl/pfdc_pin_mux.sv
// Per-pin source selection and drive shaping
`timescale 1ns/1ns
`default_nettype none
module pfdc_pin_mux (
    // Selection
    input  wire logic [7:0] alt_func_bits,
    input  wire logic [7:0] open_drain_bits,
    input  wire logic [7:0] hiDriveBits,
    // Port side
    input  wire logic [7:0] pin_direction_bit,
    input  wire logic [7:0] portOut,
    // Peripheral side
    input  wire logic [7:0] periphOut,
    input  wire logic [7:0] periphOe,
    // Pad side
    output logic      [7:0] padOut,
    output logic      [7:0] padOe,
    output logic      [7:0] padHi
);
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            logic srcOut;
            logic srcOe;
            // Direction bit high means input, as on the port
            assign srcOut = alt_func_bits[i] ? periphOut[i] : portOut[i]; // RULE1 RULE2
            assign srcOe  = alt_func_bits[i] ? periphOe[i] : ~pin_direction_bit[i]; // RULE1 RULE2
            assign padOut[i] = srcOut;
            // Open drain only ever pulls low, after the source mux
            assign padOe[i]  = srcOe & ~(open_drain_bits[i] & srcOut); // RULE4 RULE5
            assign padHi[i]  = hiDriveBits[i]; // RULE7
        end
    endgenerate
endmodule : pfdc_pin_mux
`default_nettype wire

// file: hdl/pfdc_pkg.sv
// Types for the port pin function and drive control block
package pfdc_pkg;
    typedef struct packed {
        logic [7:0] index;
        logic [7:0] altFunc;
        logic [7:0] openDrain;
        logic [7:0] hiDrive;
        logic [7:0] rdData;
    } pfdc_regs_t;

    typedef struct packed {
        logic [7:0] padOut;
        logic [7:0] padOe;
        logic [7:0] padHi;
    } pfdc_pins_t;
endpackage : pfdc_pkg

// file: hdl/pfdc_port_ctrl.sv
// Functional notes
// [RULE1] Alternate bit clear: normal port pin, direction from direction bit.
// [RULE2] Alternate bit set: peripheral controls the pin.
// [RULE3] Index 03H routes control accesses to the open-drain sub-register.
// [RULE4] Open-drain bit set disables the high driver; clear drives normally.
// [RULE5] Open-drain bits act at pins regardless of alternate function.
// [RULE6] Index 04H routes control accesses to the high-drive sub-register.
// [RULE7] High-drive bit set selects high-current drive, alternate pins included.
// [RULE8] Reset clears all open-drain bits, giving push-pull drive.
`timescale 1ns/1ns
`default_nettype none
`include "pfdc_defines.svh"
module pfdc_port_ctrl (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Register access
    input  wire logic       addrWr,
    input  wire logic       ctrlWr,
    input  wire logic       ctrlRd,
    input  wire logic [7:0] wrData,
    output logic      [7:0] rdData,
    output logic      [7:0] portIndex,
    // Port data path
    input  wire logic [7:0] pin_direction_bit,
    input  wire logic [7:0] portOut,
    // Peripheral data path
    input  wire logic [7:0] periphOut,
    input  wire logic [7:0] periphOe,
    // Pads
    output logic      [7:0] padOut,
    output logic      [7:0] padOe,
    output logic      [7:0] padHi,
    // Settings as seen by other logic
    output logic      [7:0] alt_func_bits,
    output logic      [7:0] open_drain_bits
);
    pfdc_pkg::pfdc_regs_t regs_ff;
    pfdc_pkg::pfdc_regs_t nxt_regs;
    pfdc_pkg::pfdc_pins_t pins_ff;
    pfdc_pkg::pfdc_pins_t nxt_pins;
    logic [7:0]           muxOut;
    logic [7:0]           muxOe;
    logic [7:0]           muxHi;

    pfdc_pin_mux u_mux (
        .alt_func_bits     (regs_ff.altFunc),
        .open_drain_bits   (regs_ff.openDrain),
        .hiDriveBits       (regs_ff.hiDrive),
        .pin_direction_bit (pin_direction_bit),
        .portOut           (portOut),
        .periphOut         (periphOut),
        .periphOe          (periphOe),
        .padOut            (muxOut),
        .padOe             (muxOe),
        .padHi             (muxHi)
    );

    always_comb begin
        nxt_regs = regs_ff;
        nxt_pins.padOut = muxOut;
        nxt_pins.padOe  = muxOe;
        nxt_pins.padHi  = muxHi;
        if (addrWr) begin
            nxt_regs.index = wrData;
        end
        // Indexed write lands one cycle after the index is held
        if (ctrlWr) begin
            if (regs_ff.index == `PFDC_IDX_ALTFN) begin
                nxt_regs.altFunc = wrData;
            end else if (regs_ff.index == `PFDC_IDX_OPENDRAIN) begin
                nxt_regs.openDrain = wrData; // RULE3
            end else if (regs_ff.index == `PFDC_IDX_HIDRIVE) begin
                nxt_regs.hiDrive = wrData; // RULE6
            end
        end
        if (ctrlRd) begin
            if (regs_ff.index == `PFDC_IDX_ALTFN) begin
                nxt_regs.rdData = regs_ff.altFunc;
            end else if (regs_ff.index == `PFDC_IDX_OPENDRAIN) begin
                nxt_regs.rdData = regs_ff.openDrain; // RULE3
            end else if (regs_ff.index == `PFDC_IDX_HIDRIVE) begin
                nxt_regs.rdData = regs_ff.hiDrive; // RULE6
            end else begin
                nxt_regs.rdData = `PFDC_RD_ZERO;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regs_ff.index     <= `PFDC_RST_INDEX;
            regs_ff.altFunc   <= `PFDC_RST_ALTFN;
            regs_ff.openDrain <= `PFDC_RST_OPENDRAIN; // RULE8
            regs_ff.hiDrive   <= `PFDC_RST_HIDRIVE;
            regs_ff.rdData    <= `PFDC_RD_ZERO;
            pins_ff.padOut    <= `PFDC_RST_PINS;
            pins_ff.padOe     <= `PFDC_RST_PINS;
            pins_ff.padHi     <= `PFDC_RST_PINS;
        end else begin
            regs_ff <= nxt_regs;
            pins_ff <= nxt_pins;
        end
    end

    assign rdData          = regs_ff.rdData;
    assign portIndex       = regs_ff.index;
    assign alt_func_bits   = regs_ff.altFunc;
    assign open_drain_bits = regs_ff.openDrain;
    assign padOut          = pins_ff.padOut;
    assign padOe           = pins_ff.padOe;
    assign padHi           = pins_ff.padHi;

    // Checks
    sequence odWrite_s;
        ctrlWr && regs_ff.index == `PFDC_IDX_OPENDRAIN;
    endsequence
    sequence hdWrite_s;
        ctrlWr && regs_ff.index == `PFDC_IDX_HIDRIVE;
    endsequence
    sequence altWrite_s;
        ctrlWr && regs_ff.index == `PFDC_IDX_ALTFN;
    endsequence
    sequence hdRead_s;
        ctrlRd && regs_ff.index == `PFDC_IDX_HIDRIVE;
    endsequence
    sequence altRead_s;
        ctrlRd && regs_ff.index == `PFDC_IDX_ALTFN;
    endsequence
    // Any index outside the three sub-registers
    sequence unmapped_s;
        regs_ff.index != `PFDC_IDX_ALTFN && regs_ff.index != `PFDC_IDX_OPENDRAIN
            && regs_ff.index != `PFDC_IDX_HIDRIVE;
    endsequence

    idx_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        addrWr |=> portIndex == $past(wrData))
        else $error("index write lost");
    alt_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        altWrite_s |=> alt_func_bits == $past(wrData)) // RULE2
        else $error("alternate write lost");
    hd_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        hdRead_s |=> rdData == $past(regs_ff.hiDrive)) // RULE6
        else $error("high-drive readback wrong");
    alt_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        altRead_s |=> rdData == $past(alt_func_bits)) // RULE2
        else $error("alternate readback wrong");
    unmapped_rd_a: assert property (@(posedge sys_clk) disable iff (rst)
        ctrlRd ##0 unmapped_s |=> rdData == `PFDC_RD_ZERO)
        else $error("unmapped read not zero");
    bad_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        ctrlWr ##0 unmapped_s |=> $stable(open_drain_bits) && $stable(regs_ff.hiDrive)) // RULE3 RULE6
        else $error("unmapped write changed a setting");

    // Per-pin checks, so every pin and not only pin 0 is watched
    genvar j;
    generate
        for (j = 0; j < 8; j++) begin : g_pin_chk
            pin_normal_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
                !alt_func_bits[j] |=> padOut[j] == $past(portOut[j]))
                else $error("normal pin source wrong");
            pin_alt_oe_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE2
                alt_func_bits[j] && !open_drain_bits[j] |=> padOe[j] == $past(periphOe[j]))
                else $error("alternate enable not used");
            pin_od_alt_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
                alt_func_bits[j] && open_drain_bits[j] && periphOut[j] |=> !padOe[j])
                else $error("open drain ignored on alternate pin");
            // Open drain still pulls low on an output pin
            pin_od_low_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
                open_drain_bits[j] && !alt_func_bits[j] && !pin_direction_bit[j] && !portOut[j] |=> padOe[j])
                else $error("open-drain pin not pulling low");
            pin_hd_alt_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE7
                alt_func_bits[j] |=> padHi[j] == $past(regs_ff.hiDrive[j]))
                else $error("high drive lost on alternate pin");
        end
    endgenerate


    od_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        odWrite_s |=> open_drain_bits == $past(wrData)) // RULE3
        else $error("open-drain write lost");
    hd_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        hdWrite_s |=> regs_ff.hiDrive == $past(wrData)) // RULE6
        else $error("high-drive write lost");
    od_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        ctrlRd && regs_ff.index == `PFDC_IDX_OPENDRAIN && !ctrlWr |=> rdData == open_drain_bits) // RULE3
        else $error("open-drain readback wrong");
    normal_dir_a: assert property (@(posedge sys_clk) disable iff (rst)
        !alt_func_bits[0] && !open_drain_bits[0] |=> padOe[0] == !$past(pin_direction_bit[0])) // RULE1
        else $error("normal pin direction wrong");
    alt_src_a: assert property (@(posedge sys_clk) disable iff (rst)
        alt_func_bits[0] |=> padOut[0] == $past(periphOut[0])) // RULE2
        else $error("alternate source not used");
    od_nohigh_a: assert property (@(posedge sys_clk) disable iff (rst)
        open_drain_bits[0] |=> !(padOe[0] && padOut[0])) // RULE4 RULE5
        else $error("open-drain pin driven high");
    hd_pin_a: assert property (@(posedge sys_clk) disable iff (rst)
        1'b1 |=> padHi == $past(regs_ff.hiDrive)) // RULE7
        else $error("high drive not at pin");
    od_reset_a: assert property (@(posedge sys_clk)
        $fell(rst) |-> open_drain_bits == `PFDC_RST_OPENDRAIN) // RULE8
        else $error("open-drain not cleared by reset");
endmodule : pfdc_port_ctrl
`default_nettype wire
